// [src/scd_defines.vh]
// Contract
// - inputs sampled and decoded only on the rising clock edge
// - write strobe with row and column strobes picks open/close and read/write
// - row strobe low, column high, write high: row_open, bank goes active
// - row strobe low, column high, write low: precharge, bank goes idle
// - row high, column low: column access, write low is write, high read
// - all strobes low while idle loads mode register from address and bank
// - chip select high deselects; strobes all high is no-operation
// - refresh pattern with clock enable falling while idle enters self refresh
// - self refresh exits when clock enable rises; nop or deselect presented; the decoder exits on the rise whatever the command
// - active state with clock enable falling and a command other than nop or deselect enters clock suspend
// - clock enable falling with nop or deselect enters power down
// - clock suspend ends when clock enable rises; other inputs ignored
// - power down ends when clock enable rises; nop or deselect presented; the decoder ends it on the rise whatever the command
// - active with clock enable high before, mask low enables byte lane
// - mask high masks write data and disables read drive for that lane
// - data pins driven and captured on rising clock edges
// - byte masks gate read output buffers during reads
// - byte masks suppress storage of masked bytes during writes
// - precharge with auto precharge bit high closes all banks
// - byte masks act on read output with two clocks latency
// - power down entry during a burst enters clock suspend instead
`ifndef SCD_DEFINES_VH
`define SCD_DEFINES_VH
`define SCD_MODE_NORMAL   3'h0
`define SCD_MODE_SELFREF  3'h1
`define SCD_MODE_SUSPEND  3'h2
`define SCD_MODE_PWRDOWN  3'h3
`define SCD_CMD_NONE      4'h0
`define SCD_CMD_OPEN      4'h1
`define SCD_CMD_CLOSE     4'h2
`define SCD_CMD_CLOSE_ALL 4'h3
`define SCD_CMD_READ      4'h4
`define SCD_CMD_READ_AP   4'h5
`define SCD_CMD_WRITE     4'h6
`define SCD_CMD_WRITE_AP  4'h7
`define SCD_CMD_MODE      4'h8
`define SCD_CMD_REFRESH   4'h9
`define SCD_CMD_SELFREF   4'hA
`define SCD_CMD_STOP      4'hB
`define SCD_CMD_ILLEGAL   4'hF
`define SCD_AP_BIT        10
`define SCD_COL_MSB       8
`define SCD_MASK_LAT      2
`define SCD_FIFO_DEPTH    8
`define SCD_FIFO_AW       3
`endif

// [src/scd_fifo.v]
`timescale 1ns/1ps
// ****************************************
// small synchronous fifo
// ****************************************
module scd_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             clock,    // system clock
   input  wire             rst_n,    // async reset, low
   input  wire [WIDTH-1:0] in_data,  // write word
   input  wire             in_valid, // write offered
   output wire             in_ready, // room left
   output wire [WIDTH-1:0] out_data, // head word
   output wire             out_valid,// head valid
   input  wire             out_ready // head taken
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wp_reg;
   reg [AW-1:0]    rp_reg;
   reg [AW:0]      cnt_reg;
   wire            push;
   wire            pop;
   reg [AW-1:0]    wp_next;
   reg [AW-1:0]    rp_next;

   assign in_ready  = (cnt_reg != DEPTH[AW:0]);
   assign out_valid = (cnt_reg != {(AW+1){1'b0}});
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem[rp_reg];

   // pointer wrap
   always @* begin
      wp_next = (wp_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_reg + 1'b1;
      rp_next = (rp_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_reg + 1'b1;
   end

   // storage, no reset
   always @(posedge clock) begin
      if (push)
         mem[wp_reg] <= in_data;
   end

   // pointers and fill count
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wp_reg  <= {AW{1'b0}};
         rp_reg  <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wp_reg <= wp_next;
         if (pop)
            rp_reg <= rp_next;
         if (push & ~pop)
            cnt_reg <= cnt_reg + 1'b1;
         else if (pop & ~push)
            cnt_reg <= cnt_reg - 1'b1;
      end
   end
endmodule

// [src/scd_decoder.v]
`timescale 1ns/1ps
`include "scd_defines.vh"
// ****************************************
// command decoder top
// ****************************************
module scd_decoder (
   input  wire        clock,              // system clock
   input  wire        rst_n,              // async reset, low
   input  wire        clock_enable_now,   // clock enable pin
   input  wire        chip_select_n,      // chip select, low
   input  wire        row_strobe_n,       // row strobe, low
   input  wire        column_strobe_n,    // column strobe, low
   input  wire        write_select_n,     // write select, low
   input  wire [1:0]  bank_select,        // bank select
   input  wire [12:0] address,            // address pins
   input  wire        low_byte_mask,      // low lane mask
   input  wire        high_byte_mask,     // high lane mask
   input  wire        burst_active,       // array side: burst running
   input  wire [15:0] data_pins_in,       // data pins, in
   output reg  [15:0] data_pins_out,      // data pins, out
   output reg  [1:0]  data_pins_oe_n,     // per-lane drive, low drives
   input  wire [15:0] rd_data,            // read word from array
   input  wire        rd_valid,           // read word valid
   output wire        wr_valid,           // write word available
   input  wire        wr_ready,           // array takes write word
   output wire [15:0] wr_data,            // write word
   output wire [1:0]  wr_byte_en,         // write lane enables
   output wire        wr_in_ready,        // fifo has room
   output reg  [3:0]  cmd_code,           // decoded command
   output reg  [1:0]  cmd_bank,           // addressed bank
   output reg  [8:0]  cmd_column,         // column address
   output reg  [12:0] cmd_row,            // row or opcode
   output reg         cmd_strobe,         // one cycle per command
   output reg  [14:0] mode_value,         // mode register
   output reg  [3:0]  bank_active,        // per-bank active flags
   output reg  [2:0]  power_mode          // normal/selfref/suspend/pwrdown
);
   // ****************************************
   // input synchronisers
   // ****************************************
   reg [37:0]  s1_reg;
   reg [37:0]  s2_reg;
   wire [37:0] pins_in;
   assign pins_in = {clock_enable_now, chip_select_n, row_strobe_n, column_strobe_n,
                     write_select_n, bank_select, address, low_byte_mask,
                     high_byte_mask, data_pins_in};

   // two flops per pin, sampled on rising edge
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= {38{1'b1}};
         s2_reg <= {38{1'b1}};
      end else begin
         s1_reg <= pins_in;
         s2_reg <= s1_reg;
      end
   end

   wire        cke_now;
   wire        cs_n;
   wire        ras_n;
   wire        cas_n;
   wire        we_n;
   wire [1:0]  ba;
   wire [12:0] addr;
   wire [1:0]  mask;
   wire [15:0] din;
   assign cke_now = s2_reg[37];
   assign cs_n    = s2_reg[36];
   assign ras_n   = s2_reg[35];
   assign cas_n   = s2_reg[34];
   assign we_n    = s2_reg[33];
   assign ba      = s2_reg[32:31];
   assign addr    = s2_reg[30:18];
   assign mask    = {s2_reg[16], s2_reg[17]}; // high lane, low lane
   assign din     = s2_reg[15:0];

   reg clock_enable_prev;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         clock_enable_prev <= 1'b1;
      else
         clock_enable_prev <= cke_now;
   end

   // ****************************************
   // command decode
   // ****************************************
   reg [3:0] cmd_next;
   reg [2:0] mode_next;
   reg       bank_is_active;
   reg       all_idle;
   reg       desel_or_nop;
   reg       cke_fall;
   reg       cke_rise;

   // pattern decode and legality
   always @* begin
      bank_is_active = bank_active[ba];
      all_idle       = (bank_active == 4'h0);
      desel_or_nop   = cs_n | (ras_n & cas_n & we_n);
      cke_fall       = clock_enable_prev & ~cke_now;
      cke_rise       = ~clock_enable_prev & cke_now;
      cmd_next       = `SCD_CMD_NONE;
      mode_next      = power_mode;
      case (power_mode)
         `SCD_MODE_NORMAL: begin
            if (cke_fall) begin
               if (~cs_n & ~ras_n & ~cas_n & we_n & all_idle) begin
                  cmd_next  = `SCD_CMD_SELFREF;
                  mode_next = `SCD_MODE_SELFREF;
               end else if (burst_active | (~desel_or_nop & ~all_idle))
                  mode_next = `SCD_MODE_SUSPEND;
               else if (desel_or_nop)
                  mode_next = `SCD_MODE_PWRDOWN;
            end else if (clock_enable_prev & ~cs_n) begin
               case ({ras_n, cas_n, we_n})
                  3'h3: cmd_next = bank_is_active ? `SCD_CMD_ILLEGAL
                                                   : `SCD_CMD_OPEN;
                  3'h2: cmd_next = addr[`SCD_AP_BIT] ? `SCD_CMD_CLOSE_ALL
                                                      : `SCD_CMD_CLOSE;
                  3'h5: cmd_next = !bank_is_active ? `SCD_CMD_ILLEGAL :
                                   addr[`SCD_AP_BIT] ? `SCD_CMD_READ_AP
                                                     : `SCD_CMD_READ;
                  3'h4: cmd_next = !bank_is_active ? `SCD_CMD_ILLEGAL :
                                   addr[`SCD_AP_BIT] ? `SCD_CMD_WRITE_AP
                                                     : `SCD_CMD_WRITE;
                  3'h0: cmd_next = all_idle ? `SCD_CMD_MODE : `SCD_CMD_ILLEGAL;
                  3'h1: cmd_next = (all_idle & cke_now) ? `SCD_CMD_REFRESH
                                                        : `SCD_CMD_ILLEGAL;
                  3'h6: cmd_next = burst_active ? `SCD_CMD_STOP
                                                : `SCD_CMD_ILLEGAL;
                  default: cmd_next = `SCD_CMD_NONE;
               endcase
            end
         end
         `SCD_MODE_SELFREF: begin
            if (cke_rise)
               mode_next = `SCD_MODE_NORMAL;
         end
         `SCD_MODE_SUSPEND: begin
            if (cke_rise)
               mode_next = `SCD_MODE_NORMAL;
         end
         `SCD_MODE_PWRDOWN: begin
            if (cke_rise)
               mode_next = `SCD_MODE_NORMAL;
         end
         default: mode_next = `SCD_MODE_NORMAL;
      endcase
   end

   // command outputs, bank flags, mode register
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cmd_code    <= `SCD_CMD_NONE;
         cmd_bank    <= 2'h0;
         cmd_column  <= 9'h000;
         cmd_row     <= 13'h0000;
         cmd_strobe  <= 1'b0;
         mode_value  <= 15'h0000;
         bank_active <= 4'h0;
         power_mode  <= `SCD_MODE_NORMAL;
      end else begin
         power_mode <= mode_next;
         cmd_code   <= cmd_next;
         cmd_strobe <= (cmd_next != `SCD_CMD_NONE);
         cmd_bank   <= ba;
         cmd_column <= addr[`SCD_COL_MSB:0];
         cmd_row    <= addr;
         case (cmd_next)
            `SCD_CMD_OPEN:      bank_active[ba] <= 1'b1;
            `SCD_CMD_CLOSE:     bank_active[ba] <= 1'b0;
            `SCD_CMD_CLOSE_ALL: bank_active     <= 4'h0;
            `SCD_CMD_MODE:      mode_value      <= {ba, addr};
            default: ;
         endcase
      end
   end

   // ****************************************
   // byte masks and data path
   // ****************************************
   reg        lane_ok;
   reg [1:0]  mask_d1_reg;
   reg [1:0]  mask_d2_reg;

   // masks delayed two clocks for read drive
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mask_d1_reg <= 2'h3;
         mask_d2_reg <= 2'h3;
      end else begin
         mask_d1_reg <= mask;
         mask_d2_reg <= mask_d1_reg;
      end
   end

   always @* begin
      lane_ok = clock_enable_prev & (power_mode == `SCD_MODE_NORMAL);
   end

   // read drive per lane
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         data_pins_out  <= 16'h0000;
         data_pins_oe_n <= 2'h3;
      end else begin
         data_pins_out  <= rd_data;
         data_pins_oe_n <= (rd_valid & lane_ok) ? mask_d2_reg : 2'h3;
      end
   end

   // write path through fifo, lanes masked
   wire        wr_push;
   wire [17:0] fifo_out;
   assign wr_push = lane_ok & (mask != 2'h3);
   scd_fifo #(
      .WIDTH (18),
      .DEPTH (`SCD_FIFO_DEPTH),
      .AW    (`SCD_FIFO_AW)
   ) u_fifo (
      .clock     (clock),
      .rst_n     (rst_n),
      .in_data   ({~mask, din}),
      .in_valid  (wr_push),
      .in_ready  (wr_in_ready),
      .out_data  (fifo_out),
      .out_valid (wr_valid),
      .out_ready (wr_ready)
   );
   assign wr_data    = fifo_out[15:0];
   assign wr_byte_en = fifo_out[17:16];
endmodule

// [bench/scd_assertions.sv]
`timescale 1ns/1ps
`include "scd_defines.vh"
// ****************************************
// decoder checker
// ****************************************
module scd_checker (
   input wire        clock,            // system clock
   input wire        rst_n,            // reset, low
   input wire        clock_enable_now, // clock enable
   input wire        chip_select_n,    // chip select
   input wire        row_strobe_n,     // row strobe
   input wire        column_strobe_n,  // column strobe
   input wire        write_select_n,   // write select
   input wire [1:0]  bank_select,      // bank select
   input wire [12:0] address,          // address pins
   input wire        rd_valid,         // read word valid
   input wire        wr_valid,         // write word ready
   input wire [1:0]  wr_byte_en,       // write lanes
   input wire [1:0]  data_pins_oe_n,   // lane drive
   input wire [3:0]  cmd_code,         // command code
   input wire [1:0]  cmd_bank,         // command bank
   input wire [12:0] cmd_row,          // command row
   input wire        cmd_strobe,       // command pulse
   input wire [14:0] mode_value,       // mode register
   input wire [3:0]  bank_active,      // bank flags
   input wire [2:0]  power_mode        // power state
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // cycle in which a command counts
   sequence run_s;
      clock_enable_now && $past(clock_enable_now) && power_mode == `SCD_MODE_NORMAL;
   endsequence
   // row open pattern
   sequence open_s;
      run_s ##0 !chip_select_n && !row_strobe_n && column_strobe_n && write_select_n;
   endsequence
   // read with auto precharge pattern
   sequence rdap_s;
      run_s ##0 !chip_select_n && row_strobe_n && !column_strobe_n && write_select_n
         && address[10];
   endsequence
   AST_DESELECT: assert property (chip_select_n |-> ##3 !cmd_strobe)
      else $error("deselect gave a command");
   AST_NOP: assert property (!chip_select_n && row_strobe_n && column_strobe_n
      && write_select_n |-> ##3 !cmd_strobe)
      else $error("nop gave a command");
   AST_OPEN_DECODE: assert property (open_s |-> ##3 cmd_strobe
      && cmd_bank == $past(bank_select, 3)
      && (cmd_code == `SCD_CMD_OPEN || cmd_code == `SCD_CMD_ILLEGAL))
      else $error("row open not decoded");
   AST_READ_AP: assert property (rdap_s |-> ##3 cmd_strobe
      && (cmd_code == `SCD_CMD_READ_AP || cmd_code == `SCD_CMD_ILLEGAL))
      else $error("read auto precharge not decoded");
   AST_OPEN_SETS: assert property (cmd_strobe && cmd_code == `SCD_CMD_OPEN
      |-> bank_active[cmd_bank]) else $error("opened bank not active");
   AST_CLOSE_CLEARS: assert property (cmd_strobe && cmd_code == `SCD_CMD_CLOSE
      |-> !bank_active[cmd_bank]) else $error("closed bank still active");
   AST_CLOSE_ALL: assert property (cmd_strobe && cmd_code == `SCD_CMD_CLOSE_ALL
      |-> bank_active == 4'h0) else $error("banks left active");
   AST_MODE_LOAD: assert property (cmd_strobe && cmd_code == `SCD_CMD_MODE
      |-> mode_value == {cmd_bank, cmd_row}) else $error("mode value wrong");
   AST_ILLEGAL_HOLD: assert property (cmd_strobe && cmd_code == `SCD_CMD_ILLEGAL
      |-> $stable(bank_active)) else $error("illegal command changed banks");
   AST_WAKE: assert property ($rose(clock_enable_now) && power_mode != 3'h0
      |-> ##[1:6] power_mode == `SCD_MODE_NORMAL) else $error("no wake");
   AST_OE_CAUSE: assert property (data_pins_oe_n != 2'h3 |-> $past(rd_valid))
      else $error("drive without read word");
   AST_WR_LANE: assert property (wr_valid |-> wr_byte_en != 2'h0)
      else $error("write word with no lane");
endmodule

bind scd_decoder scd_checker u_scd_checker (.clock, .rst_n, .clock_enable_now,
   .chip_select_n, .row_strobe_n, .column_strobe_n, .write_select_n, .bank_select,
   .address, .rd_valid, .wr_valid, .wr_byte_en, .data_pins_oe_n, .cmd_code, .cmd_bank,
   .cmd_row, .cmd_strobe, .mode_value, .bank_active, .power_mode);

// [bench/scd_ctrl_model.sv]
`timescale 1ns/1ps
// ****************************************
// controller model
// ****************************************
module scd_ctrl_model (
   input  wire        clock,            // system clock
   output reg         clock_enable_now, // clock enable
   output reg         chip_select_n,    // chip select
   output reg         row_strobe_n,     // row strobe
   output reg         column_strobe_n,  // column strobe
   output reg         write_select_n,   // write select
   output reg  [1:0]  bank_select,      // bank select
   output reg  [12:0] address,          // address pins
   output reg         low_byte_mask,    // low lane mask
   output reg         high_byte_mask,   // high lane mask
   output reg  [15:0] data_pins_in      // data to pins
);
   // start deselected with lanes masked
   initial begin
      {clock_enable_now, chip_select_n, row_strobe_n, column_strobe_n} = 4'hF;
      write_select_n = 1'b1;
      {bank_select, address} = 15'h0;
      {high_byte_mask, low_byte_mask} = 2'h3;
      data_pins_in = 16'h0;
   end
   // one command for one edge, then deselect with scrambled address
   task cmd(input [3:0] p, input [1:0] b, input [12:0] a, input k);
      @(negedge clock);
      {chip_select_n, row_strobe_n, column_strobe_n, write_select_n} = p;
      bank_select = b;
      address = a;
      clock_enable_now = k;
      @(negedge clock);
      {chip_select_n, row_strobe_n, column_strobe_n, write_select_n} = 4'h8;
      bank_select = ~b;
      address = ~a;
   endtask
   // clock enable change under deselect
   task cke(input k);
      @(negedge clock);
      clock_enable_now = k;
   endtask
   // one data word and lane masks {high,low}
   task word(input [1:0] m, input [15:0] d);
      @(negedge clock);
      {high_byte_mask, low_byte_mask} = m;
      data_pins_in = d;
   endtask
endmodule

// [bench/test_sdram_command_decoder.sv]
`timescale 1ns/1ps
`include "scd_defines.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
// ****************************************
// decoder testbench
// ****************************************
module test_sdram_command_decoder;
   reg         clock, rst_n, burst_active, rd_valid, wr_ready;
   reg  [15:0] rd_data;
   wire        clock_enable_now, chip_select_n, row_strobe_n, column_strobe_n;
   wire        write_select_n, low_byte_mask, high_byte_mask, wr_valid, wr_in_ready;
   wire        cmd_strobe;
   wire [1:0]  bank_select, data_pins_oe_n, wr_byte_en, cmd_bank;
   wire [12:0] address, cmd_row;
   wire [15:0] data_pins_in, data_pins_out, wr_data;
   wire [3:0]  cmd_code, bank_active;
   wire [8:0]  cmd_column;
   wire [14:0] mode_value;
   wire [2:0]  power_mode;
   int         miscompares = 0;
   int         n_compared = 0;
   int         i;

   scd_ctrl_model u_scd_ctrl_model (.clock, .clock_enable_now, .chip_select_n,
      .row_strobe_n, .column_strobe_n, .write_select_n, .bank_select, .address,
      .low_byte_mask, .high_byte_mask, .data_pins_in);
   scd_decoder u_scd_decoder (.clock, .rst_n, .clock_enable_now, .chip_select_n,
      .row_strobe_n, .column_strobe_n, .write_select_n, .bank_select, .address,
      .low_byte_mask, .high_byte_mask, .burst_active, .data_pins_in, .data_pins_out,
      .data_pins_oe_n, .rd_data, .rd_valid, .wr_valid, .wr_ready, .wr_data, .wr_byte_en,
      .wr_in_ready, .cmd_code, .cmd_bank, .cmd_column, .cmd_row, .cmd_strobe,
      .mode_value, .bank_active, .power_mode);

   // 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // verdict and end of run
   task finish_test;
      if (miscompares == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // command, then wait for its decode
   task go(input [3:0] p, input [1:0] b, input [12:0] a);
      u_scd_ctrl_model.cmd(p, b, a, 1'b1);
      @(posedge clock);
      @(posedge clock);
      #1;
   endtask
   // bounded wait for a power state
   task wait_mode(input [2:0] m);
      repeat (12) if (power_mode !== m) @(posedge clock);
      #1;
      `CHK(power_mode, m)
   endtask
   // mode set, refused read, deselect, nop, refresh
   task t_mode;
      `CHK(bank_active, 4'h0)
      `CHK(data_pins_oe_n, 2'h3)
      go(4'h0, 2'h1, 13'h0ABC);
      `CHK(mode_value, 15'h2ABC)
      go(4'h5, 2'h0, 13'h0);
      `CHK(cmd_code, `SCD_CMD_ILLEGAL)
      go(4'h8, 2'h0, 13'h0);
      `CHK(cmd_strobe, 1'b0)
      go(4'h7, 2'h0, 13'h0);
      `CHK(cmd_strobe, 1'b0)
      go(4'h1, 2'h0, 13'h0);
      `CHK(cmd_code, `SCD_CMD_REFRESH)
   endtask
   // open all four banks, then reopen one
   task t_open;
      for (i = 0; i < 4; i++) begin
         go(4'h3, i[1:0], 13'h1000 + i[12:0]);
         `CHK(cmd_bank, i[1:0])
         `CHK(cmd_row, 13'h1000 + i[12:0])
         `CHK(bank_active, 4'hF >> (3 - i))
      end
      go(4'h3, 2'h0, 13'h0);
      `CHK(cmd_code, `SCD_CMD_ILLEGAL)
      go(4'h1, 2'h0, 13'h0);
      `CHK(cmd_code, `SCD_CMD_ILLEGAL)
      go(4'h0, 2'h3, 13'h1FFF);
      `CHK(cmd_code, `SCD_CMD_ILLEGAL)
      `CHK(mode_value, 15'h2ABC)
   endtask
   // reads and writes with and without auto precharge, burst stop
   task t_column;
      for (i = 0; i < 4; i++) begin
         go({3'h2, ~i[1]}, i[1:0], {2'h0, i[0], 1'b0, 9'h1F0 + i[8:0]});
         `CHK(cmd_code, 4'h4 + i[3:0])
         `CHK(cmd_column, 9'h1F0 + i[8:0])
      end
      go(4'h6, 2'h0, 13'h0);
      `CHK(cmd_code, `SCD_CMD_ILLEGAL)
      @(negedge clock) burst_active = 1'b1;
      go(4'h6, 2'h0, 13'h0);
      `CHK(cmd_code, `SCD_CMD_STOP)
   endtask
   // power down attempt in a burst, then bank closes
   task t_close;
      u_scd_ctrl_model.cke(1'b0);
      wait_mode(`SCD_MODE_SUSPEND);
      u_scd_ctrl_model.cke(1'b1);
      wait_mode(`SCD_MODE_NORMAL);
      @(negedge clock) burst_active = 1'b0;
      go(4'h2, 2'h2, 13'h0);
      `CHK(bank_active, 4'hB)
      go(4'h2, 2'h2, 13'h0400);
      `CHK(cmd_code, `SCD_CMD_CLOSE_ALL)
      `CHK(bank_active, 4'h0)
   endtask
   // power down and self refresh while idle
   task t_idle_power;
      u_scd_ctrl_model.cke(1'b0);
      wait_mode(`SCD_MODE_PWRDOWN);
      u_scd_ctrl_model.cke(1'b1);
      wait_mode(`SCD_MODE_NORMAL);
      u_scd_ctrl_model.cmd(4'h1, 2'h0, 13'h0, 1'b0);
      wait_mode(`SCD_MODE_SELFREF);
      u_scd_ctrl_model.cke(1'b1);
      wait_mode(`SCD_MODE_NORMAL);
   endtask
   // fill write buffer past full with far side stalled, then drain
   task t_fifo;
      for (i = 0; i < 10; i++) u_scd_ctrl_model.word(2'h1, 16'hA000 + i[15:0]);
      u_scd_ctrl_model.word(2'h3, 16'h5FF6);
      repeat (4) @(negedge clock);
      `CHK(wr_in_ready, 1'b0)
      wr_ready = 1'b1;
      for (i = 0; i < 8; i++) begin
         `CHK(wr_data, 16'hA000 + i[15:0])
         `CHK(wr_byte_en, 2'h2)
         @(negedge clock);
      end
      `CHK(wr_valid, 1'b0)
   endtask
   // read drive per lane under masks
   task t_read;
      @(negedge clock);
      rd_data = 16'h5A3C;
      rd_valid = 1'b1;
      u_scd_ctrl_model.word(2'h2, 16'h0);
      repeat (8) @(negedge clock);
      `CHK(data_pins_oe_n, 2'h2)
      `CHK(data_pins_out, 16'h5A3C)
      u_scd_ctrl_model.word(2'h1, 16'h0);
      repeat (4) @(negedge clock);
      `CHK(data_pins_oe_n, 2'h2)
      @(negedge clock);
      `CHK(data_pins_oe_n, 2'h1)
      rd_valid = 1'b0;
      repeat (4) @(negedge clock);
      `CHK(data_pins_oe_n, 2'h3)
   endtask
   // reset, then scenarios
   initial begin
      rst_n = 1'b0;
      burst_active = 1'b0;
      rd_valid = 1'b0;
      wr_ready = 1'b0;
      rd_data = 16'h0;
      repeat (6) @(posedge clock);
      @(negedge clock) rst_n = 1'b1;
      t_mode;
      t_open;
      t_column;
      t_close;
      t_idle_power;
      t_fifo;
      t_read;
      finish_test;
   end
   // watchdog
   initial begin
      #200000;
      miscompares++;
      finish_test;
   end
endmodule
